// >>> design/opc_map.svh
`ifndef OPC_MAP_SVH
`define OPC_MAP_SVH
// Opcodes
`define OPC_OP_QOR        8'h6B
`define OPC_OP_QOR4       8'h6C
`define OPC_OP_QUAD_IO_READ_CMD       8'hEB
`define OPC_OP_QIOR4      8'hEC
`define OPC_OP_DDRQ       8'hED
`define OPC_OP_DDRQ4      8'hEE
`define OPC_OP_RDS1       8'h05
`define OPC_OP_RDS2       8'h07
`define OPC_OP_WRITE_ENABLE_CMD       8'h06
`define OPC_OP_SRST       8'hF0
`define OPC_OP_WRR        8'h01
`define OPC_OP_BANK       8'hB9
`define OPC_OP_OTP_PROG   8'h42
`define OPC_OP_OTP_READ   8'h4B
`define OPC_OP_CFG_READ   8'h2B
`define OPC_OP_CFG_PROG   8'h2F
`define OPC_OP_VOL_READ   8'hE0
`define OPC_OP_VOL_WRITE  8'hE1
`define OPC_OP_PER_READ   8'hE2
// Geometry
`define OPC_OTP_BYTES     1024
`define OPC_OTP_AW        10
`define OPC_SECT_BITS     8
`define OPC_SECTORS       256
`define OPC_CFG_RESET     16'hFFFF
// Self-timed busy time, microseconds and clock cycles at 25 MHz
`define OPC_BUSY_US       4
`define OPC_CLK_MHZ       25
`define OPC_BUSY_CYC      (`OPC_BUSY_US * `OPC_CLK_MHZ)
`endif

// >>> design/opc_pkg.sv
package opc_pkg;
  typedef enum logic [6:0] {
    OPC_CMD  = 7'h01,
    OPC_ADDR = 7'h02,
    OPC_DUMY = 7'h04,
    OPC_RDAT = 7'h08,
    OPC_WDAT = 7'h10,
    OPC_SKIP = 7'h20,
    OPC_HOLD = 7'h40
  } opc_state_t;
endpackage : opc_pkg

// >>> design/opc_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "opc_map.svh"
// Summary of operation
// RQ1 - In either suspend, accept quad output, quad I/O and quad DDR reads.
// RQ2 - In either suspend, accept both status register reads.
// RQ3 - Write enable accepted in erase suspend only; software reset always accepted.
// RQ4 - Register write accepted in suspend only right after a bank register access.
// RQ5 - Host drives address bits 23..10 zero for one-time region program.
// RQ6 - One-time region program is page-program style and needs the write-enable latch.
// RQ7 - Programming zeros into a locked one-time region fails and sets program error.
// RQ8 - Host reprograms only bits still one, padding others with ones.
// RQ9 - One-time read acts like fast read without wrap; past top is undefined.
// RQ10 - One-time read always has exactly one dummy byte.
// RQ11 - Config read shifts out sixteen bits on falling edges, low byte first.
// RQ12 - Config read repeats every sixteen clocks while select is low.
// RQ13 - Host keeps serial clock at or below 133 MHz for protection reads.
// RQ14 - Config program takes two data bytes low first, needs write-enable latch.
// RQ15 - Config program runs only if select rises right after bit sixteen.
// RQ16 - Config program sets busy and error flags, then clears write-enable latch.
// RQ17 - Volatile read takes a 32-bit sector address, then returns the byte.
// RQ18 - Volatile read repeats the same byte every eight clocks, no increment.
// RQ19 - Volatile write takes address and one byte; needs write-enable latch.
// RQ20 - Volatile write runs only if select rises right after bit eight.
// RQ21 - Volatile write holds busy, updates error, then clears busy and latch.
// RQ22 - Persistent read returns the sector byte, repeating every eight clocks.
// RQ23 - Writes without a decoded write enable change no flag and no content.
module opc_core
  import opc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sck_in,
  input  wire logic       si_in,
  input  wire logic       erase_susp_in,
  input  wire logic       prog_susp_in,
  input  wire logic       otp_locked_in,
  input  wire logic [7:0] persist_lock_in,
  output logic            so_out,
  output logic            so_oe_out,
  output logic            wel_out,
  output logic            wip_out,
  output logic            perr_out,
  output logic [15:0]     cfg_out,
  output logic            cmd_accept_out,
  output logic            cmd_reject_out,
  output logic [7:0]      cmd_code_out,
  output logic            srst_out
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] cs_s_q;
  logic [1:0] sck_s_q;
  logic [1:0] si_s_q;
  logic       sck_d1_q;
  logic       cs_d1_q;

  // Two flops per pin, then edge history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cs_s_q   <= 2'h3;
      sck_s_q  <= 2'h0;
      si_s_q   <= 2'h0;
      sck_d1_q <= 1'b0;
      cs_d1_q  <= 1'b1;
    end else begin
      cs_s_q   <= {cs_s_q[0], cs_n_in};
      sck_s_q  <= {sck_s_q[0], sck_in};
      si_s_q   <= {si_s_q[0], si_in};
      sck_d1_q <= sck_s_q[1];
      cs_d1_q  <= cs_s_q[1];
    end
  end

  logic cs_n;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic si_b;
  assign cs_n     = cs_s_q[1];
  assign si_b     = si_s_q[1];
  assign sck_rise = ~cs_n & sck_s_q[1] & ~sck_d1_q;
  assign sck_fall = ~cs_n & ~sck_s_q[1] & sck_d1_q;
  assign cs_rise  = cs_n & ~cs_d1_q;

  // ==========================================================
  // Command acceptance
  function automatic logic opc_allowed(input logic [7:0] op, input logic es, input logic ps,
                                       input logic bank_register_access_cmd);
    logic susp;
    susp = es | ps;
    opc_allowed = 1'b1;
    if (susp) begin
      unique case (op)
        `OPC_OP_QOR, `OPC_OP_QOR4, `OPC_OP_QUAD_IO_READ_CMD, `OPC_OP_QIOR4,
        `OPC_OP_DDRQ, `OPC_OP_DDRQ4: opc_allowed = 1'b1;  // see RQ1
        `OPC_OP_RDS1, `OPC_OP_RDS2:  opc_allowed = 1'b1;  // see RQ2
        `OPC_OP_SRST:                opc_allowed = 1'b1;  // see RQ3
        `OPC_OP_WRITE_ENABLE_CMD:                opc_allowed = ~ps;   // see RQ3
        `OPC_OP_WRR:                 opc_allowed = bank_register_access_cmd;  // see RQ4
        `OPC_OP_BANK:                opc_allowed = 1'b1;
        `OPC_OP_VOL_READ, `OPC_OP_VOL_WRITE, `OPC_OP_PER_READ: opc_allowed = ~ps;
        default:                     opc_allowed = 1'b0;
      endcase
    end
  endfunction : opc_allowed

  // Opcodes still taken while a self-timed write runs: reset and status polling
  function automatic logic opc_busy_ok(input logic [7:0] op);
    opc_busy_ok = (op == `OPC_OP_SRST) || (op == `OPC_OP_RDS1) || (op == `OPC_OP_RDS2);  // see RQ3
  endfunction : opc_busy_ok

  // ==========================================================
  // Serial state
  opc_state_t st_q;
  logic [7:0]  op_q;
  logic [7:0]  sh_q;
  logic [5:0]  bit_q;
  logic [31:0] addr_q;
  logic [15:0] wdat_q;
  logic [4:0]  wcnt_q;
  logic        last_bank_register_access_cmd_q;
  logic [15:0] cfg_q;
  logic [7:0]  vol_q [`OPC_SECTORS];
  logic [7:0]  otp_q [`OPC_OTP_BYTES];
  logic [9:0]  otp_ptr_q;
  logic [15:0] rsh_q;
  logic [4:0]  rcnt_q;

  logic [7:0] op_now;
  assign op_now = {sh_q[6:0], si_b};

  // Word loaded for outgoing data
  function automatic logic [15:0] opc_rword(input logic [7:0] op, input logic [15:0] cfg,
                                            input logic [7:0] vol, input logic [7:0] per,
                                            input logic [7:0] otp);
    unique case (op)
      `OPC_OP_CFG_READ: opc_rword = cfg;
      `OPC_OP_VOL_READ: opc_rword = {8'h00, vol};
      `OPC_OP_PER_READ: opc_rword = {8'h00, per};
      default:          opc_rword = {8'h00, otp};
    endcase
  endfunction : opc_rword

  logic [7:0] sect;
  assign sect = addr_q[23:16];
  logic [7:0] otp_rd;
  assign otp_rd = otp_q[otp_ptr_q];
  logic busy;
  logic [6:0] busy_cnt_q;
  assign busy = (busy_cnt_q != 7'h00);

  // Protocol engine, on synchronised clock edges
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q        <= OPC_CMD;
      op_q        <= 8'h00;
      sh_q        <= 8'h00;
      bit_q       <= 6'h00;
      addr_q      <= 32'h0000_0000;
      wdat_q      <= 16'h0000;
      wcnt_q      <= 5'h00;
      last_bank_register_access_cmd_q <= 1'b0;
      otp_ptr_q   <= 10'h000;
      rsh_q       <= 16'h0000;
      rcnt_q      <= 5'h00;
    end else if (cs_n) begin
      st_q   <= OPC_CMD;
      bit_q  <= 6'h00;
      wcnt_q <= 5'h00;
      if (cs_rise && st_q != OPC_CMD)
        last_bank_register_access_cmd_q <= (op_q == `OPC_OP_BANK);
    end else if (sck_rise) begin
      sh_q <= op_now;
      unique case (st_q)
        OPC_CMD: begin
          bit_q <= bit_q + 6'h01;
          if (bit_q == 6'h07) begin
            op_q  <= op_now;
            bit_q <= 6'h00;
            if (!opc_allowed(op_now, erase_susp_in, prog_susp_in, last_bank_register_access_cmd_q) || (busy && !opc_busy_ok(op_now)))
              st_q <= OPC_SKIP;
            else if (op_now == `OPC_OP_CFG_READ) begin
              st_q  <= OPC_RDAT;  // see RQ11
              rsh_q <= cfg_q;
              rcnt_q <= 5'h00;
            end else if (op_now == `OPC_OP_CFG_PROG)
              st_q <= OPC_WDAT;
            else if (op_now == `OPC_OP_OTP_PROG || op_now == `OPC_OP_OTP_READ ||
                     op_now == `OPC_OP_VOL_READ || op_now == `OPC_OP_VOL_WRITE ||
                     op_now == `OPC_OP_PER_READ)
              st_q <= OPC_ADDR;
            else
              st_q <= OPC_HOLD;
          end
        end
        OPC_ADDR: begin
          addr_q <= {addr_q[30:0], si_b};
          bit_q  <= bit_q + 6'h01;
          // One-time ops use 24-bit address, sector ops 32-bit
          if ((op_q == `OPC_OP_OTP_PROG || op_q == `OPC_OP_OTP_READ) ? (bit_q == 6'h17) : (bit_q == 6'h1F)) begin
            bit_q <= 6'h00;
            if (op_q == `OPC_OP_OTP_READ)
              st_q <= OPC_DUMY;  // see RQ10
            else if (op_q == `OPC_OP_OTP_PROG || op_q == `OPC_OP_VOL_WRITE)
              st_q <= OPC_WDAT;
            else begin
              st_q   <= OPC_RDAT;  // see RQ17
              rcnt_q <= 5'h08;
            end
          end
        end
        OPC_DUMY: begin
          bit_q <= bit_q + 6'h01;
          if (bit_q == 6'h07) begin
            st_q      <= OPC_RDAT;  // see RQ9
            otp_ptr_q <= addr_q[9:0];
            rcnt_q    <= 5'h08;
          end
        end
        OPC_WDAT: begin
          wdat_q <= {wdat_q[14:0], si_b};
          if (wcnt_q != 5'h1F)
            wcnt_q <= wcnt_q + 5'h01;
        end
        OPC_RDAT, OPC_SKIP, OPC_HOLD: begin
        end
      endcase
    end else if (sck_fall && st_q == OPC_RDAT) begin
      // Reload at word boundary: same sector, no increment except the one-time read pointer
      if (rcnt_q == 5'h00 || rcnt_q == 5'h10 || (rcnt_q == 5'h08 && op_q != `OPC_OP_CFG_READ)) begin
        rsh_q  <= opc_rword(op_q, cfg_q, vol_q[sect], persist_lock_in, otp_rd);  // see RQ12, RQ18, RQ22
        rcnt_q <= 5'h01;
        if (op_q == `OPC_OP_OTP_READ && rcnt_q == 5'h08)
          otp_ptr_q <= otp_ptr_q + 10'h001;
      end else begin
        rsh_q  <= (op_q == `OPC_OP_CFG_READ && rcnt_q == 5'h08) ? {8'h00, rsh_q[15:8]} : rsh_q;
        rcnt_q <= rcnt_q + 5'h01;
      end
    end
  end

  // Output bit: low byte first, msb of each byte first
  logic [2:0] bsel;
  assign bsel = 3'h7 - rcnt_q[2:0] + 3'h1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      so_out    <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= ~cs_n & (st_q == OPC_RDAT) & (rcnt_q != 5'h08 || op_q == `OPC_OP_CFG_READ);
      so_out    <= rsh_q[bsel];
    end
  end

  // ==========================================================
  // Commit at select rise
  logic do_write_enable_cmd;
  logic do_cfg;
  logic do_vol;
  logic do_otp;
  logic wr_ok;
  assign wr_ok   = wel_out & (st_q == OPC_WDAT);  // see RQ6, RQ14, RQ19, RQ23
  assign do_write_enable_cmd = cs_rise & (st_q == OPC_HOLD) & (op_q == `OPC_OP_WRITE_ENABLE_CMD);
  assign do_cfg  = cs_rise & wr_ok & (op_q == `OPC_OP_CFG_PROG) & (wcnt_q == 5'h10);  // see RQ15
  assign do_vol  = cs_rise & wr_ok & (op_q == `OPC_OP_VOL_WRITE) & (wcnt_q == 5'h08);  // see RQ20
  assign do_otp  = cs_rise & wr_ok & (op_q == `OPC_OP_OTP_PROG) & (wcnt_q[2:0] == 3'h0) & (wcnt_q != 5'h00);

  logic otp_fail;
  assign otp_fail = otp_locked_in & (wdat_q[7:0] != 8'hFF);  // see RQ7

  // Stored contents
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_q <= `OPC_CFG_RESET;
      for (int i = 0; i < `OPC_SECTORS; i++) vol_q[i] <= 8'hFF;
      for (int j = 0; j < `OPC_OTP_BYTES; j++) otp_q[j] <= 8'hFF;
    end else begin
      if (do_cfg)
        cfg_q <= {wdat_q[7:0], wdat_q[15:8]};  // see RQ14
      if (do_vol)
        vol_q[sect] <= wdat_q[7:0];
      if (do_otp && !otp_fail)
        otp_q[addr_q[9:0]] <= otp_q[addr_q[9:0]] & wdat_q[7:0];  // see RQ8
    end
  end

  // Status flags and busy timer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_cnt_q <= 7'h00;
      wel_out    <= 1'b0;
      wip_out    <= 1'b0;
      perr_out   <= 1'b0;
    end else begin
      if (srst_out) begin
        busy_cnt_q <= 7'h00;
        wel_out    <= 1'b0;
        wip_out    <= 1'b0;
        perr_out   <= 1'b0;
      end else if (do_cfg || do_vol || do_otp) begin
        busy_cnt_q <= 7'(`OPC_BUSY_CYC);  // see RQ16, RQ21
        wip_out    <= 1'b1;
        perr_out   <= do_otp & otp_fail;
      end else if (busy_cnt_q == 7'h01) begin
        busy_cnt_q <= 7'h00;
        if (!perr_out) begin
          wip_out <= 1'b0;
          wel_out <= 1'b0;  // see RQ16, RQ21
        end
      end else if (busy) begin
        busy_cnt_q <= busy_cnt_q - 7'h01;
      end else if (do_write_enable_cmd) begin
        wel_out <= 1'b1;
      end
    end
  end

  // Command decode reporting
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_accept_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      cmd_code_out   <= 8'h00;
      srst_out       <= 1'b0;
    end else begin
      cmd_accept_out <= 1'b0;
      cmd_reject_out <= 1'b0;
      srst_out       <= cs_rise & (st_q == OPC_HOLD) & (op_q == `OPC_OP_SRST);  // see RQ3
      if (sck_rise && st_q == OPC_CMD && bit_q == 6'h07) begin
        cmd_code_out   <= op_now;
        cmd_accept_out <= opc_allowed(op_now, erase_susp_in, prog_susp_in, last_bank_register_access_cmd_q) &
                          (~busy | opc_busy_ok(op_now));
        cmd_reject_out <= ~opc_allowed(op_now, erase_susp_in, prog_susp_in, last_bank_register_access_cmd_q) |
                          (busy & ~opc_busy_ok(op_now));
      end
    end
  end

  assign cfg_out = cfg_q;

  // ==========================================================
  // Checks
  property p_write_enable_cmd_prog_susp;
    @(posedge clk_in) disable iff (rst_in)
      (sck_rise && st_q == OPC_CMD && bit_q == 6'h07 && op_now == `OPC_OP_WRITE_ENABLE_CMD && prog_susp_in)
      |=> cmd_reject_out;
  endproperty
  a_write_enable_cmd_prog_susp: assert property (p_write_enable_cmd_prog_susp) else $error("write enable taken in program suspend"); // see RQ3

  property p_no_wel_no_wip;
    @(posedge clk_in) disable iff (rst_in)
      (cs_rise && !wel_out && !busy) |=> !wip_out;
  endproperty
  a_no_wel_no_wip: assert property (p_no_wel_no_wip) else $error("write ran without latch"); // see RQ23

  property p_cfg_busy;
    @(posedge clk_in) disable iff (rst_in)
      do_cfg |=> wip_out [*8];
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("busy not held after config program"); // see RQ16

  property p_vol_done;
    @(posedge clk_in) disable iff (rst_in || srst_out)
      do_vol |-> ##[1:120] (!wip_out && !wel_out);
  endproperty
  a_vol_done: assert property (p_vol_done) else $error("volatile write never completed"); // see RQ21

  property p_otp_err;
    @(posedge clk_in) disable iff (rst_in)
      (do_otp && otp_fail) |=> perr_out;
  endproperty
  a_otp_err: assert property (p_otp_err) else $error("locked program did not flag error"); // see RQ7

  property p_otp_ones;
    @(posedge clk_in) disable iff (rst_in)
      (do_otp && wdat_q[7:0] == 8'hFF) |=> !perr_out;
  endproperty
  a_otp_ones: assert property (p_otp_ones) else $error("programming ones flagged error"); // see RQ7

  property p_cfg_len;
    @(posedge clk_in) disable iff (rst_in)
      (cs_rise && op_q == `OPC_OP_CFG_PROG && st_q == OPC_WDAT && wcnt_q != 5'h10) |=> $stable(cfg_q);
  endproperty
  a_cfg_len: assert property (p_cfg_len) else $error("short config program took effect"); // see RQ15

  property p_vol_len;
    @(posedge clk_in) disable iff (rst_in)
      (cs_rise && op_q == `OPC_OP_VOL_WRITE && wcnt_q != 5'h08) |=> !$rose(wip_out);
  endproperty
  a_vol_len: assert property (p_vol_len) else $error("short volatile write ran"); // see RQ20

endmodule : opc_core
`default_nettype wire

// >>> verif/opc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host controller model for the serial link
module opc_host (
  output logic      cs_n_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in
);
  localparam int HALF = 160; // 3.125 MHz, far under 133 MHz

  // Idle levels, clock parked low between frames
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    si_out   = 1'b1;
  end

  // One frame: ntx bits out msb first, then nrx bits sampled in
  task automatic frame(input logic [47:0] tx, input int ntx, input int nrx, output logic [31:0] rx);
    rx = '0;
    #7;
    cs_n_out = 1'b0;
    for (int i = ntx - 1; i >= 0; i--) begin
      si_out = tx[i]; // Whole command, address and data
      #HALF;
      sck_out = 1'b1;
      #HALF;
      sck_out = 1'b0;
    end
    for (int i = 0; i < nrx; i++) begin
      si_out = ~si_out; // Not data, keep it moving
      #HALF;
      sck_out = 1'b1;
      #(HALF - 5);
      rx = {rx[30:0], so_in};
      #5;
      sck_out = 1'b0;
    end
    #HALF;
    cs_n_out = 1'b1; // Rise right after the last bit
    si_out   = ~si_out;
    #400;
  endtask : frame
endmodule : opc_host
`default_nettype wire

// >>> verif/otp_and_sector_protect_cmds_test.sv
`timescale 1ns/1ps
`default_nettype none
`define OPC_TB_CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
// ============================================================
// Self-checking bench for the protection command block
module otp_and_sector_protect_cmds_test;
  logic        clk_in, rst_in, cs_n, sck, si, esusp, psusp, otp_lock;
  logic        so, so_oe, write_enable_latch, write_in_progress, perr, acc, rej, srst;
  logic [7:0]  plock, code, od, om;
  logic [7:0]  sec[2], vb[2];
  logic [9:0]  oa, exp_v;
  logic [15:0] cfg, v16;
  logic [31:0] rx;
  logic [9:0]  exp_q[$];
  logic [8:0]  ops[11] = '{9'h16B, 9'h16C, 9'h1EB, 9'h1EC, 9'h1ED, 9'h1EE, 9'h105, 9'h107, 9'h006, 9'h0E0, 9'h0E2};
  int          n_errors, samples_checked, seed;

  opc_core opc_core_inst (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .si_in(si),
    .erase_susp_in(esusp), .prog_susp_in(psusp), .otp_locked_in(otp_lock), .persist_lock_in(plock),
    .so_out(so), .so_oe_out(so_oe), .wel_out(write_enable_latch), .wip_out(write_in_progress), .perr_out(perr), .cfg_out(cfg),
    .cmd_accept_out(acc), .cmd_reject_out(rej), .cmd_code_out(code), .srst_out(srst));
  opc_host opc_host_inst (.cs_n_out(cs_n), .sck_out(sck), .si_out(si), .so_in(so));

  // System clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Match each verdict pulse with the oldest note
  always @(negedge clk_in) begin
    if (acc === 1'b1 || rej === 1'b1) begin
      exp_v = exp_q.pop_front();
      `OPC_TB_CHK({acc, rej, code}, exp_v)
    end
  end

  // Note the verdict, then run one frame
  task automatic cmd(input logic ok, input logic [47:0] tx, input int ntx, input int nrx);
    exp_q.push_back({ok, ~ok, tx[ntx-1 -: 8]});
    @(posedge clk_in);
    #3;
    opc_host_inst.frame(tx, ntx, nrx, rx);
  endtask : cmd

  // Bounded wait for the busy flag to drop
  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 120) begin
      @(posedge clk_in);
      n++;
    end
    #5;
    `OPC_TB_CHK(n < 120, 1'b1)
  endtask : wait_idle

  // Enabled write with busy and latch checks
  task automatic wr(input logic [47:0] tx, input int ntx, input logic probe);
    cmd(1'b1, 48'h06, 8, 0);
    `OPC_TB_CHK(write_enable_latch, 1'b1)
    cmd(1'b1, tx, ntx, 0);
    `OPC_TB_CHK(write_in_progress, 1'b1)
    if (probe) cmd(1'b0, 48'h06, 8, 0);
    wait_idle();
    `OPC_TB_CHK({write_in_progress, write_enable_latch}, 2'b00)
  endtask : wr

  // Verdict and end of run
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Cut a hang short
  initial begin
    #2000000;
    n_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed = 58430;
    n_errors = 0;
    samples_checked = 0;
    rst_in = 1'b1;
    esusp = 1'b0;
    psusp = 1'b0;
    otp_lock = 1'b0;
    plock = 8'h00;
    repeat (20) @(posedge clk_in);
    #2;
    rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #2;
    `OPC_TB_CHK({write_enable_latch, write_in_progress, perr, cfg}, {3'b000, 16'hFFFF})
    // Suspend acceptance, erase then program
    for (int m = 0; m < 2; m++) begin
      esusp = (m == 0);
      psusp = (m == 1);
      foreach (ops[i]) cmd(m == 0 || ops[i][8], {40'h0, ops[i][7:0]}, 8, 0);
      cmd(1'b1, 48'hB9, 8, 0);
      cmd(1'b1, 48'h01, 8, 0);
      cmd(1'b1, 48'hF0, 8, 0);
      cmd(1'b0, 48'h01, 8, 0);
      `OPC_TB_CHK(write_enable_latch, 1'b0)
    end
    esusp = 1'b0;
    psusp = 1'b0;
    // Config register program and read
    v16 = 16'($random(seed));
    cmd(1'b1, {24'h0, 8'h2F, v16[7:0], v16[15:8]}, 24, 0);
    `OPC_TB_CHK({write_in_progress, cfg}, {1'b0, 16'hFFFF})
    wr({24'h0, 8'h2F, v16[7:0], v16[15:8]}, 24, 1'b0);
    `OPC_TB_CHK(cfg, v16)
    cmd(1'b1, 48'h06, 8, 0);
    cmd(1'b1, {25'h0, 8'h2F, ~v16[14:0]}, 23, 0);
    `OPC_TB_CHK({write_in_progress, cfg}, {1'b0, v16})
    cmd(1'b1, 48'hF0, 8, 0);
    cmd(1'b1, 48'h2B, 8, 32);
    `OPC_TB_CHK(rx, {2{v16[7:0], v16[15:8]}})
    // Volatile locks on two sectors
    sec[0] = 8'($random(seed));
    sec[1] = ~sec[0];
    for (int s = 0; s < 2; s++) begin
      vb[s] = 8'($random(seed));
      wr({8'hE1, 8'h00, sec[s], 16'h0000, vb[s]}, 48, s == 0);
    end
    cmd(1'b1, 48'h06, 8, 0);
    cmd(1'b1, {1'b0, 8'hE1, 8'h00, sec[0], 16'h0000, ~vb[0][7:1]}, 47, 0);
    cmd(1'b1, 48'hF0, 8, 0);
    for (int s = 0; s < 2; s++) begin
      cmd(1'b1, {8'h0, 8'hE0, 8'h00, sec[s], 16'h0000}, 40, 16);
      `OPC_TB_CHK(rx[15:0], {2{vb[s]}})
    end
    // Persistent lock read
    plock = 8'($random(seed));
    cmd(1'b1, {8'h0, 8'hE2, 8'h00, sec[1], 16'h0000}, 40, 24);
    `OPC_TB_CHK(rx[23:0], {3{plock}})
    // One-time region, unlocked then locked
    oa = 10'($random(seed));
    od = 8'($random(seed));
    om = ~(8'h01 << od[2:0]);
    wr({8'h0, 8'h42, 14'h0, oa, od}, 40, 1'b0);
    wr({8'h0, 8'h42, 14'h0, oa, om}, 40, 1'b0);
    cmd(1'b1, {8'h0, 8'h42, 14'h0, oa, 8'h00}, 40, 0);
    cmd(1'b1, {8'h0, 8'h4B, 14'h0, oa, 8'hFF}, 40, 8);
    `OPC_TB_CHK({perr, rx[7:0]}, {1'b0, od & om})
    otp_lock = 1'b1;
    cmd(1'b1, 48'h06, 8, 0);
    cmd(1'b1, {8'h0, 8'h42, 14'h0, ~oa, 8'h00}, 40, 0);
    `OPC_TB_CHK({perr, write_in_progress}, 2'b11)
    cmd(1'b1, 48'hF0, 8, 0);
    `OPC_TB_CHK({perr, write_in_progress, write_enable_latch}, 3'b000)
    wr({8'h0, 8'h42, 14'h0, ~oa, 8'hFF}, 40, 1'b0);
    `OPC_TB_CHK(perr, 1'b0)
    repeat (4) @(posedge clk_in);
    `OPC_TB_CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule : otp_and_sector_protect_cmds_test
`default_nettype wire
